// ==== rtl/afe_ctrl_consts.vh ====
`ifndef AFE_CTRL_CONSTS_VH
`define AFE_CTRL_CONSTS_VH

// Register byte offsets
`define OFF_FIRST_CONFIG   8'h00
`define OFF_SECOND_CONFIG  8'h04
`define OFF_GAIN           8'h08
`define OFF_STATUS         8'h0C
`define OFF_QUANT          8'h10

// Field positions
`define POS_SHUTDOWN       0
`define POS_CHAN_RESET     8
`define POS_EXT_REF        0
`define POS_EXT_CLOCK      1
`define POS_FULL_PD        0
`define POS_ALL_SHUTDOWN   1

// Reset values
`define RST_FIRST_CONFIG   32'h00000000
`define RST_SECOND_CONFIG  32'h00000000
`define RST_GAIN           32'h00000000
`define RST_THERMOMETER    4'h3

// Timing
`define MCLK_HZ            4000000
`define SAMPLE_HZ          1000000
`define SAMPLE_DIV         (`MCLK_HZ / `SAMPLE_HZ)

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== rtl/afe_power_gain_control.v ====
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_consts.vh"

// How it works
// - Full power-down needs all eight off, both selects
// - Full power-down stops clocks and supply monitors
// - Full power-down: channels off, reference off
// - Entering full power-down keeps configuration contents
// - Register port stays alive during full power-down
// - Any cleared bit restarts both supply monitors
// - Per-channel 3-bit gain: 1,2,4,8,16,32
// - Gain codes six and seven mean unity
// - Quantizer gives 4-bit thermometer, five levels
// - Modulators update once per sample clock period
// - Channel reset returns quantizer to 0011
// - Channel power-down only via first config bits

module afe_power_gain_control #(
    parameter CHANNELS = 8
) (
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire [7:0]            s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [7:0]            s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    input  wire                  master_clock,
    input  wire [3*CHANNELS-1:0] comparator_level,
    output reg                   modulator_sample_clock,
    output reg  [CHANNELS-1:0]   channel_enable,
    output reg  [6*CHANNELS-1:0] channel_gain,
    output reg  [4*CHANNELS-1:0] quantizer_code,
    output reg                   input_clock_enable,
    output reg                   core_clock_enable,
    output reg                   avdd_monitor_enable,
    output reg                   dvdd_monitor_enable,
    output reg                   vref_enable,
    output reg                   full_power_down
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoders
    function [5:0] gain_factor;
        input [2:0] code;
        begin
            case (code)
                3'h0:    gain_factor = 6'h01;
                3'h1:    gain_factor = 6'h02;
                3'h2:    gain_factor = 6'h04;
                3'h3:    gain_factor = 6'h08;
                3'h4:    gain_factor = 6'h10;
                3'h5:    gain_factor = 6'h20;
                default: gain_factor = 6'h01;
            endcase
        end
    endfunction

    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            merge_bytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[8*i +: 8] = data[8*i +: 8];
                end
            end
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'h0})
                `OFF_FIRST_CONFIG, `OFF_SECOND_CONFIG, `OFF_GAIN,
                `OFF_STATUS, `OFF_QUANT: mapped = 1'b1;
                default:                 mapped = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and power state
    reg  [31:0] first_config_word;
    reg  [31:0] second_config_word;
    reg  [31:0] gain_word;

    wire [CHANNELS-1:0] shutdown_bits = first_config_word[`POS_SHUTDOWN +: CHANNELS];
    wire [CHANNELS-1:0] reset_bits    = first_config_word[`POS_CHAN_RESET +: CHANNELS];
    wire                ext_ref_select   = second_config_word[`POS_EXT_REF];
    wire                ext_clock_select = second_config_word[`POS_EXT_CLOCK];

    // Pure AND of the live bits, so every write is seen the next cycle
    wire all_shutdown = &shutdown_bits;
    wire next_full_pd = all_shutdown & ext_ref_select & ext_clock_select;
    wire clocks_run   = ~all_shutdown;

    ////////////////////////////////////////////////////////////////////////////
    // Master clock sampling and sample-rate divider
    reg       mclk_s1;
    reg       mclk_s2;
    reg       mclk_s3;
    reg       mclk_level;
    reg [3:0] div_count;
    reg       sample_tick;

    // Edge taken only once second and third stages agree
    wire mclk_rise = (mclk_s2 == mclk_s3) & mclk_s3 & ~mclk_level;

    always @(posedge aclk) begin
        if (!aresetn) begin
            mclk_s1    <= 1'b0;
            mclk_s2    <= 1'b0;
            mclk_s3    <= 1'b0;
            mclk_level <= 1'b0;
        end else begin
            mclk_s1 <= master_clock;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
            if (mclk_s2 == mclk_s3) begin
                mclk_level <= mclk_s3;
            end
        end
    end

    // Divider cleared and held at zero while clocks are not distributed
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_count              <= 4'h0;
            sample_tick            <= 1'b0;
            modulator_sample_clock <= 1'b0;
        end else if (!clocks_run) begin
            div_count              <= 4'h0;
            sample_tick            <= 1'b0;
            modulator_sample_clock <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            if (mclk_rise) begin
                if ({28'h0000000, div_count} == `SAMPLE_DIV - 1) begin
                    div_count   <= 4'h0;
                    sample_tick <= 1'b1;
                end else begin
                    div_count <= div_count + 4'h1;
                end
                modulator_sample_clock <= ({28'h0000000, div_count} < `SAMPLE_DIV / 2);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels
    wire [4*CHANNELS-1:0] thermometer;
    reg  [3*CHANNELS-1:0] level_s1;
    reg  [3*CHANNELS-1:0] level_s2;
    reg  [3*CHANNELS-1:0] level_s3;
    reg  [3*CHANNELS-1:0] level_ok;

    always @(posedge aclk) begin
        if (!aresetn) begin
            level_s1 <= {3*CHANNELS{1'b0}};
            level_s2 <= {3*CHANNELS{1'b0}};
            level_s3 <= {3*CHANNELS{1'b0}};
            level_ok <= {3*CHANNELS{1'b0}};
        end else begin
            level_s1 <= comparator_level;
            level_s2 <= level_s1;
            level_s3 <= level_s2;
            if (level_s2 == level_s3) begin
                level_ok <= level_s3;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            quantizer_channel u_quant (
                .aclk          (aclk),
                .aresetn       (aresetn),
                .sample_tick   (sample_tick),
                .channel_reset (reset_bits[ch]),
                .channel_off   (shutdown_bits[ch]),
                .level         (level_ok[3*ch +: 3]),
                .thermometer   (thermometer[4*ch +: 4])
            );

            always @(posedge aclk) begin
                if (!aresetn) begin
                    channel_gain[6*ch +: 6] <= 6'h01;
                end else begin
                    channel_gain[6*ch +: 6] <= gain_factor(gain_word[3*ch +: 3]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Power outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            channel_enable      <= {CHANNELS{1'b0}};
            quantizer_code      <= {CHANNELS{`RST_THERMOMETER}};
            input_clock_enable  <= 1'b0;
            core_clock_enable   <= 1'b0;
            avdd_monitor_enable <= 1'b1;
            dvdd_monitor_enable <= 1'b1;
            vref_enable         <= 1'b1;
            full_power_down     <= 1'b0;
        end else begin
            full_power_down     <= next_full_pd;
            channel_enable      <= ~shutdown_bits & {CHANNELS{~next_full_pd}};
            input_clock_enable  <= clocks_run;
            core_clock_enable   <= clocks_run & ~(&reset_bits);
            avdd_monitor_enable <= ~next_full_pd;
            dvdd_monitor_enable <= ~next_full_pd;
            vref_enable         <= ~next_full_pd & ~ext_ref_select;
            quantizer_code      <= thermometer;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, alive in every power state
    reg [7:0]  wr_addr;
    reg [31:0] wr_data;
    reg [3:0]  wr_strb;
    reg        aw_held;
    reg        w_held;
    reg [31:0] read_word;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready      <= 1'b1;
            s_axi_wready       <= 1'b1;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= `RESP_OKAY;
            aw_held            <= 1'b0;
            w_held             <= 1'b0;
            wr_addr            <= 8'h00;
            wr_data            <= 32'h00000000;
            wr_strb            <= 4'h0;
            first_config_word  <= `RST_FIRST_CONFIG;
            second_config_word <= `RST_SECOND_CONFIG;
            gain_word          <= `RST_GAIN;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Power-down never touches these: only the bus writes them
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
                case ({wr_addr[7:2], 2'h0})
                    `OFF_FIRST_CONFIG: begin
                        first_config_word <= merge_bytes(first_config_word, wr_data,
                                                         wr_strb) & 32'h0000FFFF;
                    end
                    `OFF_SECOND_CONFIG: begin
                        second_config_word <= merge_bytes(second_config_word, wr_data,
                                                          wr_strb) & 32'h00000003;
                    end
                    `OFF_GAIN: begin
                        gain_word <= merge_bytes(gain_word, wr_data,
                                                 wr_strb) & 32'h00FFFFFF;
                    end
                    default: ;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @* begin
        case ({s_axi_araddr[7:2], 2'h0})
            `OFF_FIRST_CONFIG:  read_word = first_config_word;
            `OFF_SECOND_CONFIG: read_word = second_config_word;
            `OFF_GAIN:          read_word = gain_word;
            `OFF_STATUS:        read_word = {30'h00000000, all_shutdown, full_power_down};
            `OFF_QUANT:         read_word = quantizer_code;
            default:            read_word = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= read_word;
                s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // afe_power_gain_control

`default_nettype wire

// ==== rtl/quantizer_channel.v ====
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_consts.vh"

module quantizer_channel (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       sample_tick,
    input  wire       channel_reset,
    input  wire       channel_off,
    input  wire [2:0] level,
    output reg  [3:0] thermometer
);

    reg [3:0] next_thermometer;

    // Four comparators, equally spaced: level n lights n low bits
    always @* begin
        case (level)
            3'h0:    next_thermometer = 4'h0;
            3'h1:    next_thermometer = 4'h1;
            3'h2:    next_thermometer = 4'h3;
            3'h3:    next_thermometer = 4'h7;
            default: next_thermometer = 4'hF; // Over-range clips to top level
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            thermometer <= `RST_THERMOMETER;
        end else if (channel_reset || channel_off) begin
            thermometer <= `RST_THERMOMETER;
        end else if (sample_tick) begin
            thermometer <= next_thermometer;
        end
    end

endmodule // quantizer_channel

`default_nettype wire

// ==== tb/master_clock_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module master_clock_model (
    input  wire logic run,
    output var  logic master_clock
);
    // Parks low when stopped so no stale edge is left hanging
    initial begin
        master_clock = 1'h0;
        #3.1;
        forever begin
            #62.5;
            master_clock = run ? ~master_clock : 1'h0;
        end
    end
endmodule // master_clock_model

`default_nettype wire

// ==== tb/power_gain_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module power_gain_checker #(
    parameter CHANNELS = 8
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [CHANNELS-1:0]   channel_enable,
    input wire logic [6*CHANNELS-1:0] channel_gain,
    input wire logic [4*CHANNELS-1:0] quantizer_code,
    input wire logic                  input_clock_enable,
    input wire logic                  core_clock_enable,
    input wire logic                  avdd_monitor_enable,
    input wire logic                  dvdd_monitor_enable,
    input wire logic                  vref_enable,
    input wire logic                  full_power_down
);
    logic q_ok;
    logic g_ok;

    // Per-channel shape of each field
    always_comb begin
        q_ok = 1'h1;
        g_ok = 1'h1;
        for (int i = 0; i < CHANNELS; i++) begin
            if (!(quantizer_code[4*i+:4] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})) q_ok = 1'h0;
            if (!(channel_gain[6*i+:6] inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20}))
                g_ok = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_FPD_MON: assert property (full_power_down |->
        !avdd_monitor_enable && !dvdd_monitor_enable)
        else $error("monitor on in full power-down");
    AST_FPD_CLK: assert property (full_power_down |->
        !input_clock_enable && !core_clock_enable)
        else $error("clock on in full power-down");
    AST_FPD_OFF: assert property (full_power_down |->
        channel_enable == '0 && !vref_enable)
        else $error("channel or reference on in full power-down");
    AST_MON_ON: assert property (!full_power_down |->
        avdd_monitor_enable && dvdd_monitor_enable)
        else $error("monitor off outside full power-down");
    AST_GAIN: assert property (g_ok)
        else $error("gain factor outside the gain set");
    AST_THERM: assert property (q_ok)
        else $error("quantizer code not thermometer");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");

    cover property (full_power_down);
    cover property ($fell(full_power_down));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule // power_gain_checker

bind afe_power_gain_control power_gain_checker #(.CHANNELS(CHANNELS)) power_gain_checker_inst (
    .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .channel_enable, .channel_gain, .quantizer_code,
    .input_clock_enable, .core_clock_enable, .avdd_monitor_enable,
    .dvdd_monitor_enable, .vref_enable, .full_power_down
);

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctrl_consts.vh"

module testbench;
    logic        aclk, aresetn, run, master_clock, modulator_sample_clock;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, full_power_down, vref_enable;
    logic        input_clock_enable, core_clock_enable;
    logic        avdd_monitor_enable, dvdd_monitor_enable;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, channel_enable;
    logic [31:0] s_axi_wdata, s_axi_rdata, quantizer_code;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [23:0] comparator_level;
    logic [47:0] channel_gain;
    int          fail_count, compares;

    afe_power_gain_control afe_power_gain_control_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_clock, .comparator_level,
        .modulator_sample_clock, .channel_enable, .channel_gain, .quantizer_code,
        .input_clock_enable, .core_clock_enable, .avdd_monitor_enable,
        .dvdd_monitor_enable, .vref_enable, .full_power_down
    );

    master_clock_model master_clock_model_inst (.run, .master_clock);

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Answer taken one cycle late, so the hold side is exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            conclude();
        end
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        s_axi_bready <= 1'h0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            conclude();
        end
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask

    task automatic rise(output int c);
        c = 0;
        while (modulator_sample_clock !== 1'h0 && c < 200) begin
            @(posedge aclk);
            c++;
        end
        while (modulator_sample_clock !== 1'h1 && c < 200) begin
            @(posedge aclk);
            c++;
        end
        if (c >= 200) begin
            fail_count++;
            conclude();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        tick(2);
        chk("quant_reset", 32'h33333333, quantizer_code);
        chk("pd_reset", 1'h0, full_power_down);
        rd(`OFF_FIRST_CONFIG, 32'h00000000, `RESP_OKAY);
        rd(`OFF_SECOND_CONFIG, 32'h00000000, `RESP_OKAY);
        rd(8'h20, 32'h00000000, `RESP_SLVERR);
        wr(8'h24, 32'hFFFFFFFF, `RESP_SLVERR);
    endtask

    // Codes 0..7 on channels 0..7
    task automatic t_gain;
        logic [47:0] e;
        wr(`OFF_GAIN, 32'h00FAC688, `RESP_OKAY);
        for (int i = 0; i < 8; i++) e[6*i+:6] = (i < 6) ? (6'h01 << i) : 6'h01;
        tick(3);
        chk("gain", e, channel_gain);
        // Low byte lane only: upper codes must survive
        s_axi_wstrb <= 4'h1;
        wr(`OFF_GAIN, 32'h00000000, `RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`OFF_GAIN, 32'h00FAC600, `RESP_OKAY);
        wr(`OFF_GAIN, 32'h00FAC688, `RESP_OKAY);
    endtask

    // Levels 0..7 per channel; 5..7 clip to the top level
    task automatic t_quant;
        int c;
        run <= 1'h1;
        comparator_level <= 24'hFAC688;
        tick(400);
        rise(c);
        rise(c);
        chk("sample_period", 32'h00000032, c);
        chk("quant", 32'hFFFF7310, quantizer_code);
        wr(`OFF_FIRST_CONFIG, 32'h00000800, `RESP_OKAY);
        tick(3);
        chk("quant_ch_reset", 32'hFFFF3310, quantizer_code);
        wr(`OFF_FIRST_CONFIG, 32'h00000000, `RESP_OKAY);
    endtask

    task automatic t_power;
        wr(`OFF_SECOND_CONFIG, 32'h00000001, `RESP_OKAY);
        wr(`OFF_FIRST_CONFIG, 32'h000000FF, `RESP_OKAY);
        tick(3);
        chk("pd_clock_internal", 1'h0, full_power_down);
        chk("ch_all_off", 8'h00, channel_enable);
        rd(`OFF_STATUS, 32'h00000002, `RESP_OKAY);
        wr(`OFF_SECOND_CONFIG, 32'h00000003, `RESP_OKAY);
        tick(3);
        chk("pd", 1'h1, full_power_down);
        chk("monitors", 2'h0, {avdd_monitor_enable, dvdd_monitor_enable});
        chk("clocks", 2'h0, {input_clock_enable, core_clock_enable});
        chk("vref", 1'h0, vref_enable);
        rd(`OFF_STATUS, 32'h00000003, `RESP_OKAY);
        rd(`OFF_GAIN, 32'h00FAC688, `RESP_OKAY);
        rd(`OFF_FIRST_CONFIG, 32'h000000FF, `RESP_OKAY);
        wr(`OFF_SECOND_CONFIG, 32'h00000001, `RESP_OKAY);
        tick(3);
        chk("pd_left", 1'h0, full_power_down);
        chk("monitors_back", 2'h3, {avdd_monitor_enable, dvdd_monitor_enable});
        wr(`OFF_FIRST_CONFIG, 32'h000000F7, `RESP_OKAY);
        tick(3);
        chk("ch3_on", 8'h08, channel_enable);
        chk("clocks_back", 2'h3, {input_clock_enable, core_clock_enable});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        aresetn = 1'h0;
        run = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        comparator_level = 24'h000000;
        fail_count = 0;
        compares = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_gain();
        t_quant();
        t_power();
        conclude();
    end
endmodule // testbench

`default_nettype wire
